//--- logic/emc_cfg.svh
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH

// mode and coarse regulator control register, field positions
`define EMC_MC_SEL_LSB      0
`define EMC_MC_SEL_MSB      1
`define EMC_MC_DIRECT_BIT   2
`define EMC_MC_FORCE_BIT    3
`define EMC_MC_COARSE_LSB   4
`define EMC_MC_COARSE_MSB   6
`define EMC_MC_RESET        8'h00

// host command registers on apb
`define EMC_H_CTRL_ADDR     12'h000
`define EMC_H_STAT_ADDR     12'h004
`define EMC_H_ENTER_BIT     0
`define EMC_H_EXIT_BIT      1
`define EMC_H_TGT_LSB       4
`define EMC_H_TGT_MSB       5

// host pin step time
`define EMC_CLK_NS          8
`define EMC_STEP_NS         80
`define EMC_STEP_CYCLES     ((`EMC_STEP_NS + `EMC_CLK_NS - 1) / `EMC_CLK_NS)

`endif

//--- logic/emc_pkg.sv
`default_nettype none
package emc_pkg;

  typedef enum logic [1:0] {
    EMC_FULL    = 2'b00,
    EMC_REDUCED = 2'b01,
    EMC_MIN     = 2'b10,
    EMC_START   = 2'b11
  } emc_state_t;

  typedef enum logic [1:0] {
    EMC_H_IDLE  = 2'b00,
    EMC_H_DRIVE = 2'b01,
    EMC_H_STRT  = 2'b10
  } emc_host_fsm_t;

endpackage

`default_nettype wire

//--- logic/emc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface emc_if;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic pullUpEn;
  logic scl;
  logic sda;

  // an undriven pin without pull-up is taken as floating low
  assign scl = sclHostOe ? sclHostOut : pullUpEn;
  assign sda = sdaHostOe ? sdaHostOut : pullUpEn;

  modport device (
    input  scl,
    input  sda,
    output pullUpEn
  );

  modport host (
    output sclHostOut,
    output sclHostOe,
    output sdaHostOut,
    output sdaHostOe
  );
endinterface

`default_nettype wire

//--- logic/emc_device.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "emc_cfg.svh"
module emc_device
  import emc_pkg::*;
#(
  parameter int VW = 8
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  // link pins
  emc_if.device              link,
  // mode and coarse regulator control register access
  input  wire logic          regWrEn,
  input  wire logic [7:0]    regWrData,
  output logic      [7:0]    regRdData,
  // output enables configured: [0] buckboost, [1] buck, [2] ldo
  input  wire logic [2:0]    outEnCfg,
  // per-state settings
  input  wire logic [VW-1:0] bbPeakFull,
  input  wire logic [VW-1:0] bbPeakLow,
  input  wire logic [VW-1:0] bkPeakFull,
  input  wire logic [VW-1:0] bkPeakLow,
  input  wire logic [VW-1:0] vobFull,
  input  wire logic [VW-1:0] vobLow,
  // interrupt source
  input  wire logic          irqReq,
  // state and controls
  output emc_state_t         energyState,
  output logic               directActive,
  output logic      [2:0]    outEn,
  output logic      [2:0]    coarseOn,
  output logic      [VW-1:0] bbPeak,
  output logic      [VW-1:0] bkPeak,
  output logic      [VW-1:0] vobTarget,
  output logic               buckCountLowBank,
  output logic               measureEn,
  output logic               countEn,
  output logic               irqOut
);

  // synchronisers and history
  logic       sclMeta_r;
  logic       sclSync_r;
  logic       sclPrev_r;
  logic       sdaMeta_r;
  logic       sdaSync_r;
  logic       sdaPrev_r;
  logic [7:0] modeCtrl_r;
  emc_state_t state_r;
  emc_state_t stateNxt;
  logic       startSeen;
  logic       pinsStable;
  logic       directEn;
  logic       forceFull;
  logic [1:0] selField;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclMeta_r <= link.scl;
      sclSync_r <= sclMeta_r;
      sclPrev_r <= sclSync_r;
      sdaMeta_r <= link.sda;
      sdaSync_r <= sdaMeta_r;
      sdaPrev_r <= sdaSync_r;
    end
  end

  assign directEn   = modeCtrl_r[`EMC_MC_DIRECT_BIT];
  assign forceFull  = modeCtrl_r[`EMC_MC_FORCE_BIT];
  assign selField   = regWrData[`EMC_MC_SEL_MSB:`EMC_MC_SEL_LSB];
  // sda falls while scl stays high
  assign startSeen  = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
  // a pin pair that changed this cycle may be mid-transition
  assign pinsStable = (sclSync_r == sclPrev_r) && (sdaSync_r == sdaPrev_r);

  // control register; software write wins over the start clear
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      modeCtrl_r <= `EMC_MC_RESET;
    else if (regWrEn)
      modeCtrl_r <= regWrData;
    else if (startSeen)
    begin
      modeCtrl_r[`EMC_MC_DIRECT_BIT] <= 1'b0;
      if (forceFull)
        modeCtrl_r[`EMC_MC_SEL_MSB:`EMC_MC_SEL_LSB] <= EMC_FULL;
      else if (directEn)
        modeCtrl_r[`EMC_MC_SEL_MSB:`EMC_MC_SEL_LSB] <= state_r;
    end
  end

  always_comb
  begin
    stateNxt = state_r;
    if (regWrEn)
    begin
      if (selField != EMC_START)
        stateNxt = emc_state_t'(selField);
    end
    else if (startSeen)
    begin
      if (forceFull)
        stateNxt = EMC_FULL;
    end
    else if (directEn && pinsStable)
    begin
      case ({sclSync_r, sdaSync_r})
        2'b11:   stateNxt = EMC_FULL;
        2'b01:   stateNxt = EMC_REDUCED;
        2'b00:   stateNxt = EMC_MIN;
        default: stateNxt = state_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= EMC_FULL;
    else
      state_r <= stateNxt;
  end

  // registered outputs follow the state one cycle later
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      energyState   <= EMC_FULL;
      directActive  <= 1'b0;
      link.pullUpEn <= 1'b1;
      regRdData     <= `EMC_MC_RESET;
    end
    else
    begin
      energyState   <= state_r;
      directActive  <= directEn;
      link.pullUpEn <= ~directEn;
      regRdData     <= modeCtrl_r;
    end
  end

  // per output: converter enable outside minimum, coarse inside it
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gOut
      always_ff @(posedge sys_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          outEn[g]    <= 1'b0;
          coarseOn[g] <= 1'b0;
        end
        else
        begin
          outEn[g]    <= outEnCfg[g] & (state_r != EMC_MIN);
          coarseOn[g] <= modeCtrl_r[`EMC_MC_COARSE_LSB + g] & (state_r == EMC_MIN);
        end
      end
    end
  endgenerate

  // low-bias settings; buckboost keeps one count bank in both states
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bbPeak           <= '0;
      bkPeak           <= '0;
      vobTarget        <= '0;
      buckCountLowBank <= 1'b0;
    end
    else
    begin
      bbPeak           <= (state_r == EMC_REDUCED) ? bbPeakLow : bbPeakFull;
      bkPeak           <= (state_r == EMC_REDUCED) ? bkPeakLow : bkPeakFull;
      vobTarget        <= (state_r == EMC_REDUCED) ? vobLow : vobFull;
      buckCountLowBank <= (state_r == EMC_REDUCED);
    end
  end

  // register access stays alive in minimum power; measurement, counting and the request are held
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      measureEn <= 1'b0;
      countEn   <= 1'b0;
      irqOut    <= 1'b0;
    end
    else
    begin
      measureEn <= (state_r != EMC_MIN);
      countEn   <= (state_r != EMC_MIN);
      irqOut    <= irqReq & (state_r != EMC_MIN);
    end
  end

endmodule

`default_nettype wire

//--- logic/emc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "emc_cfg.svh"
module emc_host
  import emc_pkg::*;
#(
  parameter int STEP_CYCLES = `EMC_STEP_CYCLES
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link pins
  emc_if.host              link
);

  emc_host_fsm_t fsm_r;
  emc_state_t    cur_r;
  emc_state_t    tgt_r;
  emc_state_t    stepNxt;
  logic          enterPend_r;
  logic          exitPend_r;
  logic [15:0]   stepCnt_r;
  logic          stepTick;
  logic          wrCtrl;
  logic          hit;

  assign hit      = (paddr == `EMC_H_CTRL_ADDR) || (paddr == `EMC_H_STAT_ADDR);
  assign wrCtrl   = psel & penable & pready & pwrite & (paddr == `EMC_H_CTRL_ADDR);
  assign stepTick = (stepCnt_r == 16'(STEP_CYCLES - 1));

  // one wait state on every access
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= (paddr == `EMC_H_STAT_ADDR) ?
                  {26'h0, fsm_r != EMC_H_IDLE,
                   enterPend_r | exitPend_r | (cur_r != tgt_r), 2'h0, cur_r} :
                  {26'h0, tgt_r, 4'h0};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // pending commands; a new command wins over its own clear
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enterPend_r <= 1'b0;
      exitPend_r  <= 1'b0;
      tgt_r       <= EMC_FULL;
    end
    else
    begin
      if (wrCtrl & pwdata[`EMC_H_ENTER_BIT])
        enterPend_r <= 1'b1;
      else if (stepTick && fsm_r == EMC_H_IDLE)
        enterPend_r <= 1'b0;
      if (wrCtrl & pwdata[`EMC_H_EXIT_BIT])
        exitPend_r <= 1'b1;
      else if (stepTick && fsm_r == EMC_H_STRT)
        exitPend_r <= 1'b0;
      if (wrCtrl && pwdata[`EMC_H_TGT_MSB:`EMC_H_TGT_LSB] != EMC_START)
        tgt_r <= emc_state_t'(pwdata[`EMC_H_TGT_MSB:`EMC_H_TGT_LSB]);
    end
  end

  // pins change at most once per step so the device sees each level
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stepCnt_r <= 16'h0000;
    else if (stepTick)
      stepCnt_r <= 16'h0000;
    else
      stepCnt_r <= stepCnt_r + 16'h0001;
  end

  // never jump between full and minimum directly
  always_comb
  begin
    stepNxt = tgt_r;
    if ((cur_r == EMC_FULL && tgt_r == EMC_MIN) || (cur_r == EMC_MIN && tgt_r == EMC_FULL))
      stepNxt = EMC_REDUCED;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fsm_r           <= EMC_H_IDLE;
      cur_r           <= EMC_FULL;
      link.sclHostOut <= 1'b1;
      link.sdaHostOut <= 1'b1;
      link.sclHostOe  <= 1'b0;
      link.sdaHostOe  <= 1'b0;
    end
    else if (stepTick)
    begin
      case (fsm_r)
        EMC_H_IDLE:
          if (enterPend_r)
          begin
            fsm_r           <= EMC_H_DRIVE;
            cur_r           <= EMC_FULL;
            link.sclHostOut <= 1'b1;
            link.sdaHostOut <= 1'b1;
            link.sclHostOe  <= 1'b1;
            link.sdaHostOe  <= 1'b1;
          end
        EMC_H_DRIVE:
          if (exitPend_r && cur_r == EMC_FULL)
          begin
            fsm_r           <= EMC_H_STRT;
            link.sdaHostOut <= 1'b0;
          end
          else if (!exitPend_r && cur_r != tgt_r)
          begin
            cur_r           <= stepNxt;
            link.sclHostOut <= (stepNxt == EMC_FULL);
            link.sdaHostOut <= (stepNxt != EMC_MIN);
          end
          else if (exitPend_r)
          begin
            cur_r           <= (cur_r == EMC_MIN) ? EMC_REDUCED : EMC_FULL;
            link.sclHostOut <= (cur_r != EMC_MIN);
            link.sdaHostOut <= 1'b1;
          end
        EMC_H_STRT:
        begin
          // release to the pull-ups, which come back with register control
          fsm_r           <= EMC_H_IDLE;
          cur_r           <= EMC_FULL;
          link.sclHostOut <= 1'b1;
          link.sdaHostOut <= 1'b1;
          link.sclHostOe  <= 1'b0;
          link.sdaHostOe  <= 1'b0;
        end
        default:
          fsm_r <= EMC_H_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- sim/emc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module emc_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link wires
  input wire logic sclHostOut,
  input wire logic sclHostOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic pullUpEn,
  input wire logic scl,
  input wire logic sda
);
  // judge pin moves while the host really drives both wires, except the start pattern, which is judged on the pins alone
  wire drv = sclHostOe && sdaHostOe;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence fullPins;
    drv && scl && sda;
  endsequence
  sequence minPins;
    drv && !scl && !sda;
  endsequence
  sequence startPins;
    scl && $fell(sda);
  endsequence

  rst_idle_a: assert property ($fell(sys_rst) |-> pullUpEn && !sclHostOe && !sdaHostOe
    && sclHostOut && sdaHostOut) else $error("link not idle after reset");
  full_to_min_a: assert property (fullPins |=> !(!scl && !sda))
    else $error("full power moved straight to minimum");
  min_to_full_a: assert property (minPins |=> !(scl && sda))
    else $error("minimum moved straight to full power");
  min_exit_a: assert property (minPins |=> !scl)
    else $error("minimum left other than to reduced");
  start_exit_a: assert property (drv && scl && !sda |=> scl)
    else $error("start left other than to full power");
  reduced_exit_a: assert property (drv && !scl && sda |=> !(scl && !sda))
    else $error("reduced moved straight to start");
  start_clears_a: assert property (startPins |-> ##[1:6] pullUpEn)
    else $error("start did not leave direct mode");
  direct_holds_a: assert property (!pullUpEn && scl && sda |=> !pullUpEn)
    else $error("pull-ups back on without start");
  start_seen_c: cover property (startPins);
endmodule
`default_nettype wire

//--- sim/test_energy_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "emc_cfg.svh"
module test_energy_mode_control
  import emc_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        regWrEn;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic [2:0]  outEnCfg;
  logic [7:0]  bbPeakFull;
  logic [7:0]  bbPeakLow;
  logic [7:0]  bkPeakFull;
  logic [7:0]  bkPeakLow;
  logic [7:0]  vobFull;
  logic [7:0]  vobLow;
  logic        irqReq;
  emc_state_t  energyState;
  logic        directActive;
  logic [2:0]  outEn;
  logic [2:0]  coarseOn;
  logic [7:0]  bbPeak;
  logic [7:0]  bkPeak;
  logic [7:0]  vobTarget;
  logic        buckCountLowBank;
  logic        measureEn;
  logic        countEn;
  logic        irqOut;
  int          fails;
  int          nCompared;
  int          cycles;
  int          seed;
  int          i;
  logic [31:0] rdData;
  logic        errSeen;
  logic [2:0]  crs;
  logic [1:0]  sel;
  emc_state_t  st;
  emc_state_t  tg [3];

  emc_if linkIf ();
  emc_device #(.VW(8)) emc_device_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(linkIf.device),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .outEnCfg(outEnCfg),
    .bbPeakFull(bbPeakFull), .bbPeakLow(bbPeakLow), .bkPeakFull(bkPeakFull),
    .bkPeakLow(bkPeakLow), .vobFull(vobFull), .vobLow(vobLow), .irqReq(irqReq),
    .energyState(energyState), .directActive(directActive), .outEn(outEn),
    .coarseOn(coarseOn), .bbPeak(bbPeak), .bkPeak(bkPeak), .vobTarget(vobTarget),
    .buckCountLowBank(buckCountLowBank), .measureEn(measureEn), .countEn(countEn),
    .irqOut(irqOut)
  );
  emc_host #(.STEP_CYCLES(10)) emc_host_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(linkIf.host)
  );
  emc_monitor emc_monitor_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sclHostOut(linkIf.sclHostOut),
    .sclHostOe(linkIf.sclHostOe), .sdaHostOut(linkIf.sdaHostOut),
    .sdaHostOe(linkIf.sdaHostOe), .pullUpEn(linkIf.pullUpEn), .scl(linkIf.scl),
    .sda(linkIf.sda)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task wrap_up;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      wrap_up;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared = nCompared + 1;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      fails = fails + 1;
    end
  endtask

  task shuffle;
    outEnCfg   <= 3'($random(seed));
    irqReq     <= 1'($random(seed));
    bbPeakFull <= 8'($random(seed));
    bbPeakLow  <= 8'($random(seed));
    bkPeakFull <= 8'($random(seed));
    bkPeakLow  <= 8'($random(seed));
    vobFull    <= 8'($random(seed));
    vobLow     <= 8'($random(seed));
  endtask

  // outputs are registered: taken at one edge, shown one edge later
  task regWr(input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn   <= 1'b1;
    regWrData <= d;
    shuffle;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdData = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll busy, then allow sync, stability and output stages
  task hostGo(input logic [31:0] c);
    apb(1'b1, `EMC_H_CTRL_ADDR, c);
    // busy sits in bit 4 of the status word; an unknown keeps polling
    do apb(1'b0, `EMC_H_STAT_ADDR, 32'h0); while (rdData[4] !== 1'b0);
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  // reduced bias takes the low setting, every other state the full one
  function automatic logic [7:0] pickSetting(input emc_state_t s, input logic [7:0] full,
                                             input logic [7:0] low);
    return (s == EMC_REDUCED) ? low : full;
  endfunction

  task checkOuts(input emc_state_t s, input logic [2:0] c);
    logic mn;
    logic rd;
    mn = (s == EMC_MIN);
    rd = (s == EMC_REDUCED);
    chk("energyState", 32'(energyState), 32'(s));
    chk("outEn", 32'(outEn), 32'(mn ? 3'h0 : outEnCfg));
    chk("coarseOn", 32'(coarseOn), 32'(mn ? c : 3'h0));
    chk("bbPeak", 32'(bbPeak), 32'(pickSetting(s, bbPeakFull, bbPeakLow)));
    chk("bkPeak", 32'(bkPeak), 32'(pickSetting(s, bkPeakFull, bkPeakLow)));
    chk("vobTarget", 32'(vobTarget), 32'(pickSetting(s, vobFull, vobLow)));
    chk("lowBank", 32'(buckCountLowBank), 32'(rd));
    chk("measureCount", 32'({measureEn, countEn}), 32'({!mn, !mn}));
    chk("irqOut", 32'(irqOut), 32'(irqReq & !mn));
  endtask

  initial
  begin
    seed = 9429;
    fails = 0;
    nCompared = 0;
    cycles = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    shuffle;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    checkOuts(EMC_FULL, 3'h0);
    st = EMC_FULL;
    // sel 11 comes twice and must leave the state alone
    for (i = 0; i < 8; i++)
    begin
      crs = 3'($random(seed));
      sel = 2'(i);
      regWr({1'b0, crs, 2'b00, sel});
      if (sel != 2'b11)
        st = emc_state_t'(sel);
      checkOuts(st, crs);
      chk("regRdData", 32'(regRdData), 32'({1'b0, crs, 2'b00, sel}));
      chk("pullUpEn", 32'(linkIf.pullUpEn), 32'h1);
    end
    regWr({1'b0, crs, 4'b1001});
    // pins walk down to minimum, which must not count without the enable bit
    hostGo(32'h21);
    checkOuts(EMC_REDUCED, crs);
    chk("directActive", 32'(directActive), 32'h0);
    chk("pullUpEn", 32'(linkIf.pullUpEn), 32'h1);
    hostGo(32'h02);
    checkOuts(EMC_FULL, crs);
    apb(1'b0, 12'h008, 32'h0);
    chk("pslverr", 32'(errSeen), 32'h1);
    // host drives full power first so the wires never float low
    hostGo(32'h01);
    regWr({1'b0, crs, 4'b0100});
    chk("pullUpEn", 32'(linkIf.pullUpEn), 32'h0);
    chk("directActive", 32'(directActive), 32'h1);
    tg = '{EMC_MIN, EMC_FULL, EMC_REDUCED};
    for (i = 0; i < 3; i++)
    begin
      hostGo(32'(tg[i]) << 4);
      checkOuts(tg[i], crs);
      chk("hostState", 32'(rdData[1:0]), 32'(tg[i]));
    end
    apb(1'b0, `EMC_H_CTRL_ADDR, 32'h0);
    chk("hostTarget", rdData, 32'(EMC_REDUCED) << 4);
    hostGo(32'h02);
    checkOuts(EMC_FULL, crs);
    chk("directActive", 32'(directActive), 32'h0);
    chk("pullUpEn", 32'(linkIf.pullUpEn), 32'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
